/* rtl/rcss_pkg.sv */
// Constants for the radio core status and semaphore register bank.
// Assumes an AXI4-Lite master on ref_clk and status sources on the same clock.
package rcss_pkg;

  // ****************************************************************
  // Bus
  // ****************************************************************
  localparam int          ADDR_W   = 18;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // ****************************************************************
  // Register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [15:0] IDX_ENGINE_STATUS = 16'h6188;
  localparam logic [15:0] IDX_SEM_A         = 16'h618a;
  localparam logic [15:0] IDX_SEM_B         = 16'h618b;
  localparam logic [15:0] IDX_SEM_C         = 16'h618c;
  localparam logic [15:0] IDX_CORE_STATUS   = 16'h618d;
  localparam logic [15:0] IDX_SIG_STRENGTH  = 16'h618e;
  localparam logic [15:0] IDX_RANDOM        = 16'h618f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_GAIN_REDUCED = 4;
  localparam int BIT_TIMER_WAIT   = 3;
  localparam int BIT_ENGINE_IDLE  = 2;
  localparam int BIT_SYNC_SEARCH  = 1;
  localparam int BIT_OSC_POWERED  = 0;
  localparam int BIT_SEM_FLAG     = 0;
  localparam int BIT_STARVED      = 7;
  localparam int BIT_DEMOD_LO     = 5;
  localparam int BIT_FRAME_DELIM  = 4;
  localparam int BIT_CAL_RUNNING  = 3;
  localparam int BIT_PLL_LOCK     = 2;
  localparam int BIT_TX_ACTIVE    = 1;
  localparam int BIT_RX_ACTIVE    = 0;

  // ****************************************************************
  // Reset values, counts and the frequency programming off setting
  // ****************************************************************
  localparam logic [2:0]  SEM_RESET      = 3'h7;
  localparam logic [7:0]  SIG_RESET      = 8'h80;
  localparam logic [15:0] RND_RESET      = 16'h0000;
  localparam int          RND_STEPS      = 13;
  localparam logic [6:0]  FREQ_PROG_OFF  = 7'h7f;

endpackage : rcss_pkg

/* rtl/rcss_rnd.sv */
// Pseudorandom byte source for the status bank.
// Assumes advance is a one-cycle pulse from the bus logic on ref_clk.
module rcss_rnd
  import rcss_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       advance,
  output logic      [7:0] rnd_byte
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0] shift;
  } rcss_rnd_s;

  rcss_rnd_s st_q;
  rcss_rnd_s st_d;

  // Xnor feedback keeps the all-zero reset state from locking up
  function automatic logic [15:0] roll(input logic [15:0] v);
    logic fb;
    fb = ~(v[15] ^ v[14] ^ v[12] ^ v[3]);
    return {v[14:0], fb};
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    if (advance) begin
      for (int i = 0; i < RND_STEPS; i++) begin
        st_d.shift = roll(st_d.shift);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q.shift <= RND_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign rnd_byte = st_q.shift[7:0];

endmodule // rcss_rnd

/* rtl/rcss_regs.sv */
// Status and semaphore register bank of the radio core, AXI4-Lite slave.
// Assumes status inputs come from radio logic on ref_clk, no synchronisers.
module rcss_regs
  import rcss_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              gain_reduced_flag,
  input  wire logic              timer_event_wait_flag,
  input  wire logic              engine_idle_flag,
  input  wire logic              sync_search_flag,
  input  wire logic              oscillator_powered_flag,
  input  wire logic [6:0]        channel_frequency_setting,
  input  wire logic              modulator_starved_event,
  input  wire logic [1:0]        demodulator_state,
  input  wire logic              frame_delimiter_flag,
  input  wire logic              cal_running_flag,
  input  wire logic              pll_lock_flag,
  input  wire logic              tx_active_flag,
  input  wire logic              rx_active_flag,
  input  wire logic [7:0]        signal_strength_value,
  input  wire logic              signal_strength_update,
  output logic                   quick_start_ready,
  output logic [2:0]             semaphore_free,
  output logic                   modulator_starved_flag
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic              aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic              w_have;
    logic [7:0]        wbyte;
    logic              wlane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [2:0]        sem;
    logic              starved;
    logic [7:0]        sig;
    logic              quick;
  } rcss_state_s;

  localparam rcss_state_s ST_RESET = '{
    aw_have : 1'b0,
    awaddr  : '0,
    w_have  : 1'b0,
    wbyte   : 8'h00,
    wlane   : 1'b0,
    bvalid  : 1'b0,
    bresp   : RESP_OK,
    rvalid  : 1'b0,
    rdata   : 8'h00,
    rresp   : RESP_OK,
    sem     : SEM_RESET,
    starved : 1'b0,
    sig     : SIG_RESET,
    quick   : 1'b0
  };

  rcss_state_s st_q;
  rcss_state_s st_d;

  logic       aw_fire;
  logic       w_fire;
  logic       ar_fire;
  logic       rnd_advance;
  logic [7:0] rnd_byte;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Low two address bits are ignored, one register per aligned word
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [15:0] idx);
    return addr[ADDR_W-1:2] == idx;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    return hit(addr, IDX_ENGINE_STATUS) | hit(addr, IDX_SEM_A) |
           hit(addr, IDX_SEM_B) | hit(addr, IDX_SEM_C) |
           hit(addr, IDX_CORE_STATUS) | hit(addr, IDX_SIG_STRENGTH) |
           hit(addr, IDX_RANDOM);
  endfunction

  function automatic logic [2:0] sem_sel(input logic [ADDR_W-1:0] addr);
    return {hit(addr, IDX_SEM_C), hit(addr, IDX_SEM_B), hit(addr, IDX_SEM_A)};
  endfunction

  // ****************************************************************
  // Read views
  // ****************************************************************
  logic [7:0] engine_view;
  logic [7:0] core_view;

  always_comb begin
    engine_view = 8'h00;
    engine_view[BIT_GAIN_REDUCED] = gain_reduced_flag;
    engine_view[BIT_TIMER_WAIT] = timer_event_wait_flag;
    engine_view[BIT_ENGINE_IDLE] = engine_idle_flag;
    engine_view[BIT_SYNC_SEARCH] = sync_search_flag;
    engine_view[BIT_OSC_POWERED] = oscillator_powered_flag;
  end

  always_comb begin
    core_view = 8'h00;
    core_view[BIT_STARVED] = st_q.starved;
    core_view[BIT_DEMOD_LO +: 2] = demodulator_state;
    core_view[BIT_FRAME_DELIM] = frame_delimiter_flag;
    core_view[BIT_CAL_RUNNING] = cal_running_flag;
    core_view[BIT_PLL_LOCK] = pll_lock_flag;
    core_view[BIT_TX_ACTIVE] = tx_active_flag;
    core_view[BIT_RX_ACTIVE] = rx_active_flag;
  end

  function automatic logic [7:0] read_value(input logic [ADDR_W-1:0] addr,
                                            input logic [7:0] eng,
                                            input logic [7:0] core,
                                            input logic [2:0] sem,
                                            input logic [7:0] sig,
                                            input logic [7:0] rnd);
    logic [7:0] v;
    logic [2:0] s;
    v = 8'h00;
    s = sem_sel(addr) & sem;
    if (hit(addr, IDX_ENGINE_STATUS)) begin
      v = eng;
    end
    if (s != 3'h0) begin
      v[BIT_SEM_FLAG] = 1'b1;
    end
    if (hit(addr, IDX_CORE_STATUS)) begin
      v = core;
    end
    if (hit(addr, IDX_SIG_STRENGTH)) begin
      v = sig;
    end
    if (hit(addr, IDX_RANDOM)) begin
      v = rnd;
    end
    return v;
  endfunction

  // ****************************************************************
  // Handshakes
  // ****************************************************************
  // Address and data are held apart so either may arrive first
  assign s_axi_awready = ~st_q.aw_have & ~st_q.bvalid;
  assign s_axi_wready  = ~st_q.w_have & ~st_q.bvalid;
  assign s_axi_arready = ~st_q.rvalid;
  assign aw_fire       = s_axi_awvalid & s_axi_awready;
  assign w_fire        = s_axi_wvalid & s_axi_wready;
  assign ar_fire       = s_axi_arvalid & s_axi_arready;
  assign rnd_advance   = ar_fire & hit(s_axi_araddr, IDX_RANDOM);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;

    if (aw_fire) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr  = s_axi_awaddr;
    end
    if (w_fire) begin
      st_d.w_have = 1'b1;
      st_d.wbyte  = s_axi_wdata[7:0];
      st_d.wlane  = s_axi_wstrb[0];
    end

    // Read side: value is taken before the claim clears it
    if (ar_fire) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = read_value(s_axi_araddr, engine_view, core_view,
                               st_q.sem, st_q.sig, rnd_byte);
      st_d.rresp  = mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
      st_d.sem    = st_q.sem & ~sem_sel(s_axi_araddr);
    end
    if (st_q.rvalid & s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end

    // Write side: commits once both halves are held
    if (st_q.aw_have & st_q.w_have & ~st_q.bvalid) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = mapped(st_q.awaddr) ? RESP_OK : RESP_ERR;
      if (st_q.wlane) begin
        // only a written 1 sets a semaphore
        if (st_q.wbyte[BIT_SEM_FLAG]) begin
          st_d.sem = st_d.sem | sem_sel(st_q.awaddr);
        end
        if (hit(st_q.awaddr, IDX_CORE_STATUS) & ~st_q.wbyte[BIT_STARVED]) begin
          st_d.starved = 1'b0;
        end
      end
      // other status bits have no write path
    end
    if (st_q.bvalid & s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    if (modulator_starved_event) begin
      st_d.starved = 1'b1;
    end

    if (signal_strength_update) begin
      st_d.sig = signal_strength_value;
    end

    // fast start with frequency programming off
    st_d.quick = oscillator_powered_flag & engine_idle_flag &
                 (channel_frequency_setting == FREQ_PROG_OFF);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Random source
  // ****************************************************************
  // advance after the value is sampled
  rcss_rnd u_rnd (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .advance  (rnd_advance),
    .rnd_byte (rnd_byte)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_bresp            = st_q.bresp;
  assign s_axi_bvalid           = st_q.bvalid;
  assign s_axi_rdata            = {24'h000000, st_q.rdata};
  assign s_axi_rresp            = st_q.rresp;
  assign s_axi_rvalid           = st_q.rvalid;
  assign quick_start_ready      = st_q.quick;
  assign semaphore_free         = st_q.sem;
  assign modulator_starved_flag = st_q.starved;

endmodule // rcss_regs

/* bench/rcss_regs_monitor.sv */
// Concurrent checks on the status and semaphore register bank.
// Assumes one clock domain, ref_clk, with rst as its asynchronous reset.
module rcss_regs_monitor
  import rcss_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              s_axi_bvalid,
  input wire logic              gain_reduced_flag,
  input wire logic              timer_event_wait_flag,
  input wire logic              engine_idle_flag,
  input wire logic              sync_search_flag,
  input wire logic              oscillator_powered_flag,
  input wire logic [6:0]        channel_frequency_setting,
  input wire logic              modulator_starved_event,
  input wire logic [1:0]        demodulator_state,
  input wire logic              frame_delimiter_flag,
  input wire logic              cal_running_flag,
  input wire logic              pll_lock_flag,
  input wire logic              tx_active_flag,
  input wire logic              rx_active_flag,
  input wire logic              quick_start_ready,
  input wire logic [2:0]        semaphore_free,
  input wire logic              modulator_starved_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  localparam logic [ADDR_W-1:0] A_ENG  = {IDX_ENGINE_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] A_SEMA = {IDX_SEM_A, 2'h0};
  localparam logic [ADDR_W-1:0] A_SEMB = {IDX_SEM_B, 2'h0};
  localparam logic [ADDR_W-1:0] A_CORE = {IDX_CORE_STATUS, 2'h0};
  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence ar_at(a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_read_latency: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
  a_sem_claim: assert property (
    ar_at(A_SEMA) ##0 semaphore_free[0] |=> s_axi_rdata == 32'h1 && !semaphore_free[0])
    else $error("semaphore claim wrong");
  a_sem_set_src: assert property (
    $rose(semaphore_free[0]) |-> $rose(s_axi_bvalid)) else $error("semaphore set without write");
  a_sem_upper: assert property (
    ar_at(A_SEMB) |=> s_axi_rdata == {31'h0, $past(semaphore_free[1])})
    else $error("semaphore read wrong");
  a_engine_live: assert property (
    ar_at(A_ENG) |=> s_axi_rdata == {27'h0, $past({gain_reduced_flag,
    timer_event_wait_flag, engine_idle_flag, sync_search_flag, oscillator_powered_flag})})
    else $error("engine status read wrong");
  a_core_live: assert property (
    ar_at(A_CORE) |=> s_axi_rdata[6:0] == $past({demodulator_state, frame_delimiter_flag,
    cal_running_flag, pll_lock_flag, tx_active_flag, rx_active_flag}))
    else $error("core status read wrong");
  a_quick_start: assert property (
    oscillator_powered_flag && engine_idle_flag && channel_frequency_setting == 7'h7f
    |=> quick_start_ready) else $error("quick start missing");
  a_starve_set: assert property (
    modulator_starved_event |=> modulator_starved_flag) else $error("starve flag not set");
  a_starve_clear: assert property (
    $fell(modulator_starved_flag) |-> $rose(s_axi_bvalid)) else $error("starve flag lost");
endmodule // rcss_regs_monitor

bind rcss_regs rcss_regs_monitor rcss_regs_monitor_i (.ref_clk, .rst, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
  .gain_reduced_flag, .timer_event_wait_flag, .engine_idle_flag, .sync_search_flag,
  .oscillator_powered_flag, .channel_frequency_setting, .modulator_starved_event,
  .demodulator_state, .frame_delimiter_flag, .cal_running_flag, .pll_lock_flag,
  .tx_active_flag, .rx_active_flag, .quick_start_ready, .semaphore_free,
  .modulator_starved_flag);

/* bench/rcss_regs_test.sv */
// Self-checking bench for the status and semaphore register bank.
// Assumes the bench is the only bus master and drives all status inputs.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module rcss_regs_test
  import rcss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] A_ENG  = {IDX_ENGINE_STATUS, 2'h0};
  localparam logic [17:0] A_CORE = {IDX_CORE_STATUS, 2'h0};
  localparam logic [17:0] A_SIG  = {IDX_SIG_STRENGTH, 2'h0};
  localparam logic [17:0] A_RND  = {IDX_RANDOM, 2'h0};
  logic ref_clk = 0, rst = 1;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rdata_dummy;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, qsr, starved;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] eng_in = '0;
  logic [6:0] core_in = '0, chan = '0;
  logic [7:0] sig_val = '0;
  logic starve_ev = 0, sig_upd = 0;
  logic [2:0] sem_free;
  logic [17:0] sem_addr [3];
  logic [15:0] lfsr;
  int fails = 0, samples_checked = 0, cyc = 0;
  // ****************************************************************
  // Clock, timeout, verdict
  // ****************************************************************
  always #2 ref_clk = ~ref_clk;
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  rcss_regs rcss_regs_i (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gain_reduced_flag(eng_in[4]), .timer_event_wait_flag(eng_in[3]),
    .engine_idle_flag(eng_in[2]), .sync_search_flag(eng_in[1]),
    .oscillator_powered_flag(eng_in[0]), .channel_frequency_setting(chan),
    .modulator_starved_event(starve_ev), .demodulator_state(core_in[6:5]),
    .frame_delimiter_flag(core_in[4]), .cal_running_flag(core_in[3]),
    .pll_lock_flag(core_in[2]), .tx_active_flag(core_in[1]), .rx_active_flag(core_in[0]),
    .signal_strength_value(sig_val), .signal_strength_update(sig_upd),
    .quick_start_ready(qsr), .semaphore_free(sem_free), .modulator_starved_flag(starved));
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    d = rdata; r = rresp; rready <= 0;
  endtask
  task automatic rc(input logic [17:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(r, RESP_OK)
    `CHK(d, e)
  endtask
  function automatic logic [15:0] adv(input logic [15:0] s);
    repeat (RND_STEPS) s = {s[14:0], ~(s[15] ^ s[14] ^ s[12] ^ s[3])};
    return s;
  endfunction
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    sem_addr = '{{IDX_SEM_A, 2'h0}, {IDX_SEM_B, 2'h0}, {IDX_SEM_C, 2'h0}};
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    rc(A_SIG, 32'h80);
    rc(A_ENG, 32'h0);
    lfsr = 16'h0;
    for (int i = 0; i < 3; i++) begin
      rc(A_RND, {24'h0, lfsr[7:0]});
      lfsr = adv(lfsr);
    end
    for (int i = 0; i < 3; i++) begin
      rc(sem_addr[i], 32'h1);
      rc(sem_addr[i], 32'h0);
      `CHK(sem_free[i], 1'b0)
      wr(sem_addr[i], 32'hfe, RESP_OK);
      rc(sem_addr[i], 32'h0);
      wr(sem_addr[i], 32'hff, RESP_OK);
      rc(sem_addr[i], 32'h1);
    end
    for (int i = 0; i < 5; i++) begin
      eng_in <= 5'h1 << i;
      rc(A_ENG, 32'h1 << i);
      wr(A_ENG, 32'h0, RESP_OK);
      rc(A_ENG, 32'h1 << i);
    end
    for (int i = 0; i < 9; i++) begin
      core_in <= (i < 4) ? 7'(i << 5) : 7'(1 << (i - 4));
      rc(A_CORE, (i < 4) ? 32'(i << 5) : 32'(1 << (i - 4)));
    end
    core_in <= 7'h0;
    starve_ev <= 1;
    @(posedge ref_clk) starve_ev <= 0;
    rc(A_CORE, 32'h80);
    wr(A_CORE, 32'h80, RESP_OK);
    rc(A_CORE, 32'h80);
    wr(A_CORE, 32'h0, RESP_OK);
    rc(A_CORE, 32'h0);
    `CHK(starved, 1'b0)
    sig_val <= 8'h3c;
    sig_upd <= 1;
    @(posedge ref_clk) sig_upd <= 0;
    rc(A_SIG, 32'h3c);
    wr(A_SIG, 32'h0, RESP_OK);
    rc(A_SIG, 32'h3c);
    // Late acceptance, the answer must stand until taken
    @(posedge ref_clk);
    araddr <= A_SIG;
    arvalid <= 1;
    do begin
      @(posedge ref_clk);
    end while (!arready);
    arvalid <= 0;
    repeat (3) @(posedge ref_clk);
    `CHK(rvalid, 1'b1)
    `CHK(rdata, 32'h3c)
    `CHK(rresp, RESP_OK)
    rready <= 1;
    do begin
      @(posedge ref_clk);
    end while (!rvalid);
    rready <= 0;
    // Unmapped hole between engine status and first semaphore
    wr(18'h18624, 32'h1, RESP_ERR);
    rd(18'h18624, rdata_dummy, resp);
    `CHK(resp, RESP_ERR)
    `CHK(rdata_dummy, 32'h0)
    eng_in <= 5'h5;
    chan <= FREQ_PROG_OFF;
    repeat (2) @(posedge ref_clk);
    `CHK(qsr, 1'b1)
    chan <= 7'h7e;
    repeat (2) @(posedge ref_clk);
    `CHK(qsr, 1'b0)
    close_out();
  end
endmodule // rcss_regs_test
